/* File: hdl/pal_alarm.sv */
// one alarm channel: latching, acknowledge, power-up policy
// assumes cond_i already merges the comparison and any fault
`timescale 1ns/1ns
`include "pal_regs.svh"
module pal_alarm (
	input  wire logic                 mclk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 cond_i,
	input  wire logic                 latching_i,
	input  wire logic                 ack_enable_i,
	input  wire pal_pkg::pal_pwr_type power_up_i,
	input  wire logic                 ack_i,
	output logic                      active_o,
	output logic                      ackable_o
);
	import pal_pkg::*;
	pal_state_type state_reg;
	pal_state_type state_next;
	logic          first_reg;
	logic          first_next;

	assign active_o  = (state_reg == PAL_ST_ACTIVE) || (state_reg == PAL_ST_HELD);
	// held latch always ackable; live alarm only if enabled
	assign ackable_o = (state_reg == PAL_ST_HELD) ||                 // see [R05]
		((state_reg == PAL_ST_ACTIVE) && ack_enable_i);               // see [R04]

	always_comb begin
		state_next = state_reg;
		first_next = 1'b0;
		if (first_reg) begin
			case (power_up_i)
				`PAL_PWR_NORMAL: state_next = cond_i ? PAL_ST_ACTIVE : PAL_ST_IDLE; // see [R08]
				`PAL_PWR_FORCED: state_next = cond_i ? PAL_ST_ACTIVE : PAL_ST_HELD; // see [R09]
				`PAL_PWR_SUPPR:  state_next = cond_i ? PAL_ST_ACKED : PAL_ST_IDLE;  // see [R10]
				default:         state_next = PAL_ST_IDLE;
			endcase
		end else begin
			case (state_reg)
				PAL_ST_IDLE: begin
					if (cond_i)
						state_next = PAL_ST_ACTIVE;
				end
				PAL_ST_ACTIVE: begin
					if (ack_i && ack_enable_i)
						state_next = PAL_ST_ACKED;    // see [R18]
					else if (!cond_i)
						state_next = latching_i ? PAL_ST_HELD : PAL_ST_IDLE; // see [R02] see [R03]
				end
				PAL_ST_HELD: begin
					if (ack_i)
						state_next = cond_i ? PAL_ST_ACKED : PAL_ST_IDLE; // see [R02]
					else if (cond_i)
						state_next = PAL_ST_ACTIVE;
				end
				PAL_ST_ACKED: begin
					if (!cond_i)
						state_next = PAL_ST_IDLE;     // see [R18] see [R10]
				end
				default: state_next = PAL_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state_reg <= PAL_ST_IDLE;
			first_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			first_reg <= first_next;
		end
	end
endmodule : pal_alarm

/* File: hdl/pal_pkg.sv */
// types shared by the process alarm logic
// assumes pal_regs.svh supplies the numeric constants
`include "pal_regs.svh"
package pal_pkg;
	typedef logic [1:0] pal_pwr_type;
	typedef logic [1:0] pal_fault_type;
	typedef enum logic [3:0] {
		PAL_ST_IDLE   = 4'h1,
		PAL_ST_ACTIVE = 4'h2,
		PAL_ST_HELD   = 4'h4,
		PAL_ST_ACKED  = 4'h8
	} pal_state_type;
endpackage : pal_pkg

/* File: hdl/pal_rate.sv */
// rate-of-change detector: compares pv change over a time base with the threshold
// assumes one-second tick from the top and a time base given in seconds
`timescale 1ns/1ns
`include "pal_regs.svh"
module pal_rate (
	input  wire logic                 mclk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 tick_i,
	input  wire logic [`PAL_PV_W-1:0] pv_i,
	input  wire logic [`PAL_PV_W-1:0] alarm_threshold_i,
	input  wire logic [`PAL_TB_W-1:0] time_base_i,
	output logic                      trip_o
);
	import pal_pkg::*;
	logic [`PAL_PV_W-1:0] ref_reg;
	logic [`PAL_PV_W-1:0] ref_next;
	logic [`PAL_TB_W-1:0] sec_reg;
	logic [`PAL_TB_W-1:0] sec_next;
	logic                 trip_reg;
	logic                 trip_next;
	logic [`PAL_PV_W-1:0] delta;

	// change over the window, threshold over time base gives the rate limit
	always_comb begin
		delta     = (pv_i >= ref_reg) ? pv_i - ref_reg : ref_reg - pv_i;
		ref_next  = ref_reg;
		sec_next  = sec_reg;
		trip_next = trip_reg;
		if (tick_i) begin
			if (sec_reg + `PAL_ONE16 >= time_base_i) begin
				trip_next = (delta >= alarm_threshold_i); // see [R16] see [R17]
				ref_next  = pv_i;
				sec_next  = `PAL_ZERO16;
			end else begin
				sec_next = sec_reg + `PAL_ONE16;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ref_reg  <= `PAL_ZERO16;
			sec_reg  <= `PAL_ZERO16;
			trip_reg <= 1'b0;
		end else begin
			ref_reg  <= ref_next;
			sec_reg  <= sec_next;
			trip_reg <= trip_next;
		end
	end
	assign trip_o = trip_reg;
endmodule : pal_rate

/* File: hdl/pal_regs.svh */
// constants for the process alarm logic: codes, widths, reset values
// assumes inclusion by the package and the modules that need the numbers
`ifndef PAL_REGS_SVH
`define PAL_REGS_SVH
`define PAL_PV_W        16
`define PAL_MSG_W       72
`define PAL_TB_W        16
`define PAL_PWR_NORMAL  2'h0
`define PAL_PWR_FORCED  2'h1
`define PAL_PWR_SUPPR   2'h2
`define PAL_FAULT_NONE  2'h0
`define PAL_FAULT_ALM1  2'h1
`define PAL_FAULT_ALM2  2'h2
`define PAL_DWELL_CYC   24'h5F5E10
`define PAL_TICK_CYC    25'h17D7840
`define PAL_ZERO16      16'h0000
`define PAL_ONE16       16'h0001
`define PAL_ZERO24      24'h000000
`define PAL_ONE24       24'h000001
`define PAL_ZERO25      25'h0000000
`define PAL_ONE25       25'h0000001
`endif

/* File: hdl/pal_top.sv */
// alarm handling for one control loop: two alarms, ack key, messages, fault, rate
// assumes key press is a one-cycle pulse and inputs are synchronous to mclk_i
// How it works
// [R01] two alarms, each with own settings
// [R02] latching alarm holds until acknowledged
// [R03] non-latching alarm clears with condition
// [R04] ack enable allows acknowledging live alarm
// [R05] cleared latched alarm always acknowledgeable
// [R06] key lamp lit while anything is ackable
// [R07] first press acks alarm one, then two
// [R08] normal power-up follows present condition
// [R09] forced power-up always starts active
// [R10] suppressed power-up waits for clear, recur
// [R11] messages per alarm, alternate when several
// [R12] fault alarms on lost pv signal
// [R13] fault goes to one alarm only
// [R14] fault adds to normal comparison
// [R15] rate trip with break action forces manual
// [R16] rate alarm on change within time base
// [R17] rate limit is threshold over time base
// [R18] live ack drops output until recurrence
`timescale 1ns/1ns
`include "pal_regs.svh"
module pal_top (
	input  wire logic                   mclk_i,
	input  wire logic                   rst_n_i,
	input  wire logic [1:0]             compare_i,
	input  wire logic [1:0]             rate_type_i,
	input  wire logic [1:0]             latching_i,
	input  wire logic [1:0]             ack_enable_i,
	input  wire pal_pkg::pal_pwr_type   power_up1_i,
	input  wire pal_pkg::pal_pwr_type   power_up2_i,
	input  wire logic [`PAL_MSG_W-1:0]  message1_i,
	input  wire logic [`PAL_MSG_W-1:0]  message2_i,
	input  wire logic                   diag_pending_i,
	input  wire logic [`PAL_MSG_W-1:0]  diag_message_i,
	input  wire pal_pkg::pal_fault_type fault_assign_i,
	input  wire logic                   pv_lost_i,
	input  wire logic [`PAL_PV_W-1:0]   pv_i,
	input  wire logic [`PAL_PV_W-1:0]   alarm_threshold1_i,
	input  wire logic [`PAL_PV_W-1:0]   alarm_threshold2_i,
	input  wire logic [`PAL_TB_W-1:0]   time_base_i,
	input  wire logic                   break_action_i,
	input  wire logic                   ack_key_i,
	output logic [1:0]                  alarm_o,
	output logic                        ack_lamp_o,
	output logic                        msg_valid_o,
	output logic [`PAL_MSG_W-1:0]       msg_o,
	output logic                        input_break_response_o
);
	import pal_pkg::*;

	logic [1:0]           rate_trip;
	logic [1:0]           cond;
	logic [1:0]           active;
	logic [1:0]           ackable;
	logic [1:0]           ack_pulse;
	logic [`PAL_PV_W-1:0] thr [2];
	logic                 tick;

	logic [24:0]          tick_cnt_reg;
	logic [24:0]          tick_cnt_next;
	logic [23:0]          dwell_reg;
	logic [23:0]          dwell_next;
	logic [1:0]           sel_reg;
	logic [1:0]           sel_next;
	logic [1:0]           alarm_reg;
	logic                 lamp_reg;
	logic                 msg_valid_reg;
	logic                 msg_valid_next;
	logic [`PAL_MSG_W-1:0] msg_reg;
	logic [`PAL_MSG_W-1:0] msg_next;
	logic                 brk_reg;

	// fault routed by a single code, so at most one alarm sees it
	function automatic logic fault_hits(input pal_fault_type sel, input int idx);
		fault_hits = (idx == 0) ? (sel == `PAL_FAULT_ALM1) : (sel == `PAL_FAULT_ALM2); // see [R13]
	endfunction : fault_hits

	// pending check for message slot 0..2
	function automatic logic slot_pending(input logic [1:0] s, input logic [1:0] act,
		input logic diag);
		case (s)
			2'h0:    slot_pending = act[0];
			2'h1:    slot_pending = act[1];
			2'h2:    slot_pending = diag;
			default: slot_pending = 1'b0;
		endcase
	endfunction : slot_pending

	assign thr[0] = alarm_threshold1_i;
	assign thr[1] = alarm_threshold2_i;

	// one-second tick for the rate time base
	always_comb begin
		tick          = (tick_cnt_reg == `PAL_TICK_CYC - `PAL_ONE25);
		tick_cnt_next = tick ? `PAL_ZERO25 : tick_cnt_reg + `PAL_ONE25;
	end

	// alarm one is served first; alarm two only when one is not ackable
	assign ack_pulse[0] = ack_key_i && ackable[0];                 // see [R07]
	assign ack_pulse[1] = ack_key_i && ackable[1] && !ackable[0];  // see [R07]

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_alm // see [R01]
			pal_rate u_rate (
				.mclk_i            (mclk_i),
				.rst_n_i           (rst_n_i),
				.tick_i            (tick),
				.pv_i              (pv_i),
				.alarm_threshold_i (thr[g]),
				.time_base_i       (time_base_i),
				.trip_o            (rate_trip[g])
			);
			// normal or rate comparison, plus the additive fault
			assign cond[g] = (rate_type_i[g] ? rate_trip[g] : compare_i[g]) ||
				(pv_lost_i && fault_hits(fault_assign_i, g)); // see [R12] see [R14]
			pal_alarm u_alarm (
				.mclk_i       (mclk_i),
				.rst_n_i      (rst_n_i),
				.cond_i       (cond[g]),
				.latching_i   (latching_i[g]),
				.ack_enable_i (ack_enable_i[g]),
				.power_up_i   ((g == 0) ? power_up1_i : power_up2_i),
				.ack_i        (ack_pulse[g]),
				.active_o     (active[g]),
				.ackable_o    (ackable[g])
			);
		end
	endgenerate

	// message rotation: each pending message dwells, then the next pending one
	always_comb begin
		sel_next       = sel_reg;
		dwell_next     = dwell_reg;
		msg_valid_next = 1'b0;
		msg_next       = msg_reg;
		if (!slot_pending(sel_reg, active, diag_pending_i) ||
			dwell_reg == `PAL_DWELL_CYC - `PAL_ONE24) begin
			dwell_next = `PAL_ZERO24;
			sel_next   = (sel_reg == 2'h2) ? 2'h0 : sel_reg + 2'h1; // see [R11]
		end else begin
			dwell_next = dwell_reg + `PAL_ONE24;
		end
		if (slot_pending(sel_reg, active, diag_pending_i)) begin
			msg_valid_next = 1'b1;
			case (sel_reg)
				2'h0:    msg_next = message1_i;
				2'h1:    msg_next = message2_i;
				default: msg_next = diag_message_i;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			tick_cnt_reg  <= `PAL_ZERO25;
			dwell_reg     <= `PAL_ZERO24;
			sel_reg       <= 2'h0;
			alarm_reg     <= 2'h0;
			lamp_reg      <= 1'b0;
			msg_valid_reg <= 1'b0;
			msg_reg       <= {`PAL_MSG_W{1'b0}};
			brk_reg       <= 1'b0;
		end else begin
			tick_cnt_reg  <= tick_cnt_next;
			dwell_reg     <= dwell_next;
			sel_reg       <= sel_next;
			alarm_reg     <= active;
			lamp_reg      <= |ackable;                                      // see [R06]
			msg_valid_reg <= msg_valid_next;
			msg_reg       <= msg_next;
			brk_reg       <= break_action_i && |(rate_trip & rate_type_i); // see [R15]
		end
	end

	assign alarm_o                = alarm_reg;
	assign ack_lamp_o             = lamp_reg;
	assign msg_valid_o            = msg_valid_reg;
	assign msg_o                  = msg_reg;
	assign input_break_response_o = brk_reg;
endmodule : pal_top

/* File: tb/pal_checker.sv */
// concurrent checks on the alarm block ports: both alarms and the key lamp
// assumes binding onto pal_top; checks pause while any rate alarm is in use
`timescale 1ns/1ns
`include "pal_regs.svh"
module pal_checker (
	input	wire logic				mclk_i,
	input	wire logic				rst_n_i,
	input	wire logic [1:0]			compare_i,
	input	wire logic [1:0]			rate_type_i,
	input	wire logic [1:0]			latching_i,
	input	wire logic [1:0]			ack_enable_i,
	input	wire pal_pkg::pal_pwr_type	power_up1_i,
	input	wire pal_pkg::pal_fault_type	fault_assign_i,
	input	wire logic				pv_lost_i,
	input	wire logic				ack_key_i,
	input	wire logic [1:0]			alarm_o,
	input	wire logic				ack_lamp_o
);
	import pal_pkg::*;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i || rate_type_i != 2'h0);
	logic c1;
	assign c1 = compare_i[0] | (pv_lost_i & (fault_assign_i == `PAL_FAULT_ALM1));
	property p_nolatch;
		(!latching_i[0] && power_up1_i != `PAL_PWR_FORCED && !c1) [*2] |=> !alarm_o[0];
	endproperty
	a_nolatch: assert property (p_nolatch) else $error("alarm1 kept without latch");
	property p_latch;
		latching_i[0] && alarm_o[0] && !ack_key_i && !$past(ack_key_i) |=> alarm_o[0];
	endproperty
	a_latch: assert property (p_latch) else $error("latched alarm1 dropped");
	property p_lamp;
		$rose(alarm_o[0]) && ack_enable_i[0] |-> ack_lamp_o;
	endproperty
	a_lamp: assert property (p_lamp) else $error("lamp dark with ackable alarm");
	property p_live_ack;
		alarm_o[0] && ack_enable_i[0] && ack_key_i |-> ##2 !alarm_o[0];
	endproperty
	a_live_ack: assert property (p_live_ack) else $error("live ack ignored");
	property p_refuse;
		latching_i[0] && !ack_enable_i[0] && alarm_o[0] && c1 && $past(c1) && $past(c1, 2)
			&& ack_key_i |-> ##2 alarm_o[0];
	endproperty
	a_refuse: assert property (p_refuse) else $error("disabled ack took effect");
	property p_order;
		ack_key_i && !$past(ack_key_i) && alarm_o == 2'h3 && ack_enable_i == 2'h3
			&& latching_i[1] |-> ##2 alarm_o[1];
	endproperty
	a_order: assert property (p_order) else $error("one press acked both");
	property p_forced;
		$rose(rst_n_i) && power_up1_i == `PAL_PWR_FORCED |-> ##[2:3] alarm_o[0];
	endproperty
	a_forced: assert property (p_forced) else $error("forced power-up inactive");
	property p_delay;
		$rose(rst_n_i) && power_up1_i == `PAL_PWR_SUPPR |-> !alarm_o[0] [*3];
	endproperty
	a_delay: assert property (p_delay) else $error("suppressed power-up active");
	property p_fault;
		$rose(pv_lost_i) && !$past(compare_i[1]) ##0
			(pv_lost_i && !ack_key_i && fault_assign_i == `PAL_FAULT_ALM2) [*3] |=> alarm_o[1];
	endproperty
	a_fault: assert property (p_fault) else $error("lost input did not alarm");
	c_both: cover property (ack_key_i && alarm_o == 2'h3);
	c_fault: cover property (pv_lost_i && alarm_o[1]);
	c_drop: cover property ($fell(alarm_o[0]));
endmodule : pal_checker
bind pal_top pal_checker u_chk (.mclk_i, .rst_n_i, .compare_i, .rate_type_i, .latching_i,
	.ack_enable_i, .power_up1_i, .fault_assign_i, .pv_lost_i, .ack_key_i, .alarm_o, .ack_lamp_o);

/* File: tb/pal_panel.sv */
// front panel key and process variable source
// assumes calls come at the falling edge of mclk_i
`timescale 1ns/1ns
`include "pal_regs.svh"
module pal_panel (
	input	wire logic			mclk_i,
	output	logic				ack_key_o,
	output	logic				pv_lost_o,
	output	logic [`PAL_PV_W-1:0]	pv_o
);
	initial begin
		ack_key_o = 1'b0;
		pv_lost_o = 1'b0;
		pv_o = 16'h0000;
	end
	// a lost input reads as a moving pattern, not a held value
	always @(negedge mclk_i) pv_o <= pv_lost_o ? ~pv_o : pv_o + 16'h0001;
	task automatic press();
		ack_key_o = 1'b1;
		@(negedge mclk_i);
		ack_key_o = 1'b0;
		@(negedge mclk_i);
	endtask : press
	task automatic set_lost(input logic v);
		pv_lost_o = v;
	endtask : set_lost
endmodule : pal_panel

/* File: tb/tb_top.sv */
// self-checking bench: alarm lifecycle, key order, power-up policies, fault
// assumes pal_checker is bound to the design and pal_panel plays the panel
`timescale 1ns/1ns
`include "pal_regs.svh"
module tb_top;
	import pal_pkg::*;
	logic			mclk_i = 1'b0;
	logic			rst_n_i = 1'b0;
	logic [1:0]		compare_i, rate_type_i, latching_i, ack_enable_i, alarm_o;
	pal_pwr_type		power_up1_i, power_up2_i;
	pal_fault_type		fault_assign_i;
	logic [`PAL_MSG_W-1:0]	message1_i, message2_i, diag_message_i, msg_o;
	logic [`PAL_PV_W-1:0]	pv_i, alarm_threshold1_i, alarm_threshold2_i, time_base_i;
	logic			break_action_i, diag_pending_i, ack_key_i, pv_lost_i;
	logic			ack_lamp_o, msg_valid_o, input_break_response_o;
	logic [76:0]		q[$];
	int			bad_count = 0;
	int			checks_done = 0;
	int			cyc = 0;
	always #20 mclk_i = ~mclk_i;
	pal_top dut (.mclk_i, .rst_n_i, .compare_i, .rate_type_i, .latching_i, .ack_enable_i,
		.power_up1_i, .power_up2_i, .message1_i, .message2_i, .diag_pending_i,
		.diag_message_i, .fault_assign_i, .pv_lost_i, .pv_i, .alarm_threshold1_i,
		.alarm_threshold2_i, .time_base_i, .break_action_i, .ack_key_i, .alarm_o,
		.ack_lamp_o, .msg_valid_o, .msg_o, .input_break_response_o);
	pal_panel panel (.mclk_i, .ack_key_o(ack_key_i), .pv_lost_o(pv_lost_i), .pv_o(pv_i));
	task automatic complete_run();
		if (bad_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [76:0] seen, input logic [76:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] alarm_state exp %h seen %h", exp, seen);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(negedge mclk_i);
	endtask : step
	// expected {break, lamp, alarm2, alarm1, msg valid, msg} once the answer has landed
	// sel: 1 alarm one message, 2 alarm two message, 3 diagnostic, 0 nothing shown
	task automatic note(input logic [2:0] v, input logic [1:0] sel);
		logic [`PAL_MSG_W-1:0] m;
		step(4);
		case (sel)
			2'h1:    m = message1_i;
			2'h2:    m = message2_i;
			2'h3:    m = diag_message_i;
			default: m = {`PAL_MSG_W{1'b0}};
		endcase
		q.push_back({1'b0, v, sel != 2'h0, m});
	endtask : note
	task automatic restart(input pal_pwr_type p1, input pal_pwr_type p2);
		rst_n_i = 1'b0;
		power_up1_i = p1;
		power_up2_i = p2;
		step(3);
		rst_n_i = 1'b1;
	endtask : restart
	always @(negedge mclk_i) begin
		#5;
		if (q.size() > 0)
			chk({input_break_response_o, ack_lamp_o, alarm_o, msg_valid_o,
				(msg_valid_o ? msg_o : {`PAL_MSG_W{1'b0}})}, q.pop_front());
	end
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			complete_run();
		end
	end
	initial begin
		void'($urandom(66));
		message1_i = 72'({$urandom, $urandom, $urandom});
		message2_i = 72'({$urandom, $urandom, $urandom});
		diag_message_i = 72'({$urandom, $urandom, $urandom});
		alarm_threshold1_i = 16'($urandom);
		alarm_threshold2_i = 16'($urandom);
		time_base_i = 16'($urandom);
		break_action_i = 1'($urandom);
		// diagnostic held off until the end so the alarm messages are not parked behind it
		diag_pending_i = 1'b0;
		rate_type_i = 2'h0;
		fault_assign_i = `PAL_FAULT_NONE;
		latching_i = 2'h1;
		ack_enable_i = 2'h1;
		compare_i = 2'h1;
		power_up1_i = `PAL_PWR_NORMAL;
		power_up2_i = `PAL_PWR_NORMAL;
		step(1);
		restart(`PAL_PWR_NORMAL, `PAL_PWR_NORMAL);
		note(3'h5, 2'h1);
		compare_i = 2'h0;
		note(3'h5, 2'h1);
		ack_enable_i = 2'h0;
		panel.press();
		ack_enable_i = 2'h1;
		note(3'h0, 2'h0);
		compare_i = 2'h1;
		note(3'h5, 2'h1);
		panel.press();
		note(3'h0, 2'h0);
		note(3'h0, 2'h0);
		compare_i = 2'h0;
		step(2);
		compare_i = 2'h1;
		note(3'h5, 2'h1);
		ack_enable_i = 2'h0;
		panel.press();
		note(3'h1, 2'h1);
		compare_i = 2'h3;
		note(3'h3, 2'h1);
		compare_i = 2'h1;
		note(3'h1, 2'h1);
		latching_i = 2'h3;
		ack_enable_i = 2'h3;
		compare_i = 2'h3;
		note(3'h7, 2'h1);
		panel.press();
		note(3'h6, 2'h2);
		panel.press();
		note(3'h0, 2'h0);
		compare_i = 2'h0;
		latching_i = 2'h0;
		ack_enable_i = 2'h0;
		fault_assign_i = `PAL_FAULT_ALM2;
		note(3'h0, 2'h0);
		panel.set_lost(1'b1);
		note(3'h2, 2'h2);
		fault_assign_i = `PAL_FAULT_ALM1;
		note(3'h1, 2'h1);
		panel.set_lost(1'b0);
		compare_i = 2'h2;
		note(3'h2, 2'h2);
		latching_i = 2'h1;
		ack_enable_i = 2'h1;
		fault_assign_i = `PAL_FAULT_NONE;
		compare_i = 2'h1;
		restart(`PAL_PWR_SUPPR, `PAL_PWR_FORCED);
		note(3'h6, 2'h2);
		compare_i = 2'h0;
		step(2);
		compare_i = 2'h1;
		note(3'h7, 2'h2);
		compare_i = 2'h0;
		restart(`PAL_PWR_FORCED, `PAL_PWR_NORMAL);
		note(3'h5, 2'h1);
		diag_pending_i = 1'b1;
		panel.press();
		note(3'h0, 2'h3);
		// rate selected: no trip before the first window ends, so compare_i is ignored
		rate_type_i = 2'h3;
		compare_i = 2'h3;
		note(3'h0, 2'h3);
		step(2);
		complete_run();
	end
endmodule : tb_top
